// >>> dcadc_defines.svh
`ifndef DCADC_DEFINES_SVH
`define DCADC_DEFINES_SVH

// Result width and the clamp codes, in two's complement form
`define DCADC_RES_W 10
`define DCADC_CODE_MAX 10'h1FF
`define DCADC_CODE_MIN 10'h200
`define DCADC_CODE_MSB 10'h200
// Input units per result step: full scale at low gain is -512 to +511 input units
`define DCADC_IN_LIM_POS 511
`define DCADC_IN_LIM_NEG -512
// Latencies in half clock cycles from the sampling (falling) edge
`define DCADC_LAT_PAR_HALF 5
`define DCADC_LAT_MUX_I_HALF 5
`define DCADC_LAT_MUX_Q_HALF 6
// Clock figures
`define DCADC_CLK_PERIOD_NS 50
`define DCADC_RATE_MAX_MSPS 30
`define DCADC_CLK_MIN_MHZ 1

`endif

// >>> dcadc_pkg.sv
package dcadc_pkg;
  typedef enum logic {
    DCADC_MUXED,
    DCADC_PARALLEL
  } dcadc_mode_type;

  typedef enum logic {
    DCADC_OFFSET_BIN,
    DCADC_TWOS_COMP
  } dcadc_format_type;
endpackage

// >>> dcadc_buf2.sv
`timescale 1ns/1ps
module dcadc_buf2 #(
  parameter int WIDTH = 20
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  logic [WIDTH-1:0] mem_q [2];
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic [1:0] count_q;
  logic push;
  logic pop;

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("dcadc_buf2 needs WIDTH of at least 1");
    end
  endgenerate

  assign push = i_in_valid && (count_q != 2'h2);
  assign pop = (count_q != 2'h0) && i_out_ready;
  assign o_in_ready = (count_q != 2'h2);
  assign o_out_valid = (count_q != 2'h0);
  assign o_out_data = mem_q[rd_ptr_q];

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end else if (push) begin
      mem_q[wr_ptr_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      if (push && !pop) begin
        count_q <= count_q + 2'h1;
      end else if (pop && !push) begin
        count_q <= count_q - 2'h1;
      end
    end
  end
endmodule

// >>> dcadc_core.sv
// Functional notes
// - Both channels are captured together on every falling clock edge while conversion runs.
// - Parallel mode drives each channel on its own bus after the rising edge.
// - Multiplexed mode shows I after rising edge, Q after falling edge, same bus.
// - Parallel results appear two and a half cycles after sampling.
// - Multiplexed I appears after 2.5 cycles, Q after 3 cycles.
// - Conversion runs every cycle while sleep and quick idle are both low and the word buffer has room.
// - Bus select high selects parallel mode.
// - Bus select low interleaves onto the I bus and holds Q bus low.
// - Input below negative range limit gives the negative full scale code.
// - Input above positive range limit gives the positive full scale code.
// - Ten bit results per channel at up to 30 MSPS.
// - One clock serves both channels and all output timing.
// - Format select low gives offset binary, high gives two's complement.
// - Quick idle holds the last result before idle on the outputs.
// - Sleep and quick idle both high behaves as sleep.
`timescale 1ns/1ps
`include "dcadc_defines.svh"
module dcadc_core
  import dcadc_pkg::*;
#(
  parameter int DIFF_W = 12,
  parameter int RES_W = `DCADC_RES_W,
  parameter int CLK_MHZ = 1000 / `DCADC_CLK_PERIOD_NS
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic signed [DIFF_W-1:0] i_i_diff,
  input wire logic signed [DIFF_W-1:0] i_q_diff,
  input wire logic i_gain_select,
  input wire logic i_bus_arrangement_select,
  input wire logic i_code_format_select,
  input wire logic i_sleep_request,
  input wire logic i_quick_idle_request,
  output logic [RES_W-1:0] o_i_bus,
  output logic [RES_W-1:0] o_q_bus,
  output logic o_chan_phase_q,
  output logic o_sleeping,
  output logic o_quick_idle,
  output logic o_word_valid,
  input wire logic i_word_ready,
  output logic [2*RES_W-1:0] o_word
);
  localparam logic signed [DIFF_W-1:0] LIM_POS = DIFF_W'(`DCADC_IN_LIM_POS);
  localparam logic signed [DIFF_W-1:0] LIM_NEG = DIFF_W'(`DCADC_IN_LIM_NEG);
  localparam int NSYNC = 5;

  generate
    if (RES_W != `DCADC_RES_W || DIFF_W < RES_W + 1) begin : g_bad_width
      $error("dcadc_core supports ten bit results and DIFF_W above RES_W");
    end
    if (CLK_MHZ > `DCADC_RATE_MAX_MSPS || CLK_MHZ < `DCADC_CLK_MIN_MHZ) begin : g_bad_rate
      $error("dcadc_core clock must lie between 1 and 30 MHz");
    end
  endgenerate

  logic [NSYNC-1:0] pins_in;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;
  dcadc_mode_type mode_q;
  dcadc_format_type fmt_q;
  logic gain_q;
  logic run_q;
  logic buf_ready;
  logic adv;
  logic signed [DIFF_W-1:0] smp_i_q;
  logic signed [DIFF_W-1:0] smp_q_q;
  logic [RES_W-1:0] s1_i_q;
  logic [RES_W-1:0] s1_q_q;
  logic [RES_W-1:0] s2_i_q;
  logic [RES_W-1:0] s2_q_q;
  logic [2:0] vld_q;
  logic adv_seen_q;
  logic [RES_W-1:0] par_i_q;
  logic [RES_W-1:0] par_q_q;
  logic [RES_W-1:0] mux_q_q;

  function automatic logic [RES_W-1:0] f_code(input logic signed [DIFF_W-1:0] d, input logic g,
                                               input dcadc_format_type f);
    logic signed [DIFF_W-1:0] s;
    logic [RES_W-1:0] c;
    s = g ? (d >>> 1) : d;
    if (s < LIM_NEG) begin
      c = `DCADC_CODE_MIN;
    end else if (s > LIM_POS) begin
      c = `DCADC_CODE_MAX;
    end else begin
      c = s[RES_W-1:0];
    end
    return (f == DCADC_TWOS_COMP) ? c : (c ^ `DCADC_CODE_MSB);
  endfunction

  assign pins_in = {i_gain_select, i_code_format_select, i_bus_arrangement_select,
                    i_quick_idle_request, i_sleep_request};

  generate
    for (genvar b = 0; b < NSYNC; b++) begin : g_sync
      always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
          sync1_q[b] <= 1'b0;
          sync2_q[b] <= 1'b0;
        end else begin
          sync1_q[b] <= pins_in[b];
          sync2_q[b] <= sync1_q[b];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode_q <= DCADC_MUXED;
      fmt_q <= DCADC_OFFSET_BIN;
      gain_q <= 1'b0;
      run_q <= 1'b0;
      o_sleeping <= 1'b0;
      o_quick_idle <= 1'b0;
    end else begin
      mode_q <= sync2_q[2] ? DCADC_PARALLEL : DCADC_MUXED;
      fmt_q <= sync2_q[3] ? DCADC_TWOS_COMP : DCADC_OFFSET_BIN;
      gain_q <= sync2_q[4];
      run_q <= !sync2_q[0] && !sync2_q[1];
      o_sleeping <= sync2_q[0];
      o_quick_idle <= sync2_q[1] && !sync2_q[0];
    end
  end

  // A full word buffer stalls the whole pipeline, like idle, so no word is lost
  assign adv = run_q && buf_ready;

  // Sampling and conversion stages run on the falling edge of the one clock
  always_ff @(negedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      smp_i_q <= '0;
      smp_q_q <= '0;
      s1_i_q <= '0;
      s1_q_q <= '0;
      s2_i_q <= '0;
      s2_q_q <= '0;
      vld_q <= 3'h0;
    end else if (adv) begin
      smp_i_q <= i_i_diff;
      smp_q_q <= i_q_diff;
      s1_i_q <= f_code(smp_i_q, gain_q, fmt_q);
      s1_q_q <= f_code(smp_q_q, gain_q, fmt_q);
      s2_i_q <= s1_i_q;
      s2_q_q <= s1_q_q;
      vld_q <= {vld_q[1:0], 1'b1};
    end
  end

  always_ff @(negedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      adv_seen_q <= 1'b0;
    end else begin
      adv_seen_q <= adv && vld_q[1];
    end
  end

  // Rising edge 2.5 cycles after sampling; idle leaves the last result standing
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      par_i_q <= '0;
      par_q_q <= '0;
    end else if (adv_seen_q) begin
      par_i_q <= s2_i_q;
      par_q_q <= s2_q_q;
    end
  end

  // Q word moves to the shared bus on the following falling edge, 3.0 cycles
  always_ff @(negedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mux_q_q <= '0;
    end else begin
      mux_q_q <= par_q_q;
    end
  end

  // Half-cycle bus steering needs the clock level itself; flops feed both sides
  assign o_i_bus = (mode_q == DCADC_MUXED && !i_clock) ? mux_q_q : par_i_q;
  assign o_q_bus = (mode_q == DCADC_PARALLEL) ? par_q_q : '0;
  assign o_chan_phase_q = (mode_q == DCADC_MUXED) && !i_clock;

  dcadc_buf2 #(
    .WIDTH(2 * RES_W)
  ) u_buf (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_in_valid(adv_seen_q),
    .o_in_ready(buf_ready),
    .i_in_data({s2_i_q, s2_q_q}),
    .o_out_valid(o_word_valid),
    .i_out_ready(i_word_ready),
    .o_out_data(o_word)
  );

  property p_sample_both;
    @(negedge i_clock) disable iff (!i_arst_n) adv |=> (smp_i_q == $past(i_i_diff)) && (smp_q_q == $past(i_q_diff));
  endproperty
  a_sample_both: assert property (p_sample_both) else $error("channels not sampled together");

  property p_par_update;
    @(posedge i_clock) disable iff (!i_arst_n) adv_seen_q |=> (par_i_q == $past(s2_i_q)) && (par_q_q == $past(s2_q_q));
  endproperty
  a_par_update: assert property (p_par_update) else $error("parallel result not updated");

  property p_hold_idle;
    @(posedge i_clock) disable iff (!i_arst_n) (!run_q) [*2] |=> $stable(par_i_q) && $stable(par_q_q);
  endproperty
  a_hold_idle: assert property (p_hold_idle) else $error("outputs moved while idle");

  property p_mux_q_follow;
    @(posedge i_clock) disable iff (!i_arst_n) $past(i_arst_n) |-> mux_q_q == par_q_q;
  endproperty
  a_mux_q_follow: assert property (p_mux_q_follow) else $error("Q word not moved half cycle later");

  property p_q_bus_low;
    @(posedge i_clock) disable iff (!i_arst_n) (sync2_q[2] == 1'b0) |=> o_q_bus == '0;
  endproperty
  a_q_bus_low: assert property (p_q_bus_low) else $error("Q bus not low in multiplexed mode");

  property p_clamp_neg;
    @(negedge i_clock) disable iff (!i_arst_n)
      adv && !gain_q && (smp_i_q < LIM_NEG) |=>
        s1_i_q == (($past(fmt_q) == DCADC_TWOS_COMP) ? 10'h200 : 10'h000);
  endproperty
  a_clamp_neg: assert property (p_clamp_neg) else $error("negative clamp wrong");

  property p_clamp_pos;
    @(negedge i_clock) disable iff (!i_arst_n)
      adv && gain_q && ((smp_q_q >>> 1) > LIM_POS) |=>
        s1_q_q == (($past(fmt_q) == DCADC_TWOS_COMP) ? 10'h1FF : 10'h3FF);
  endproperty
  a_clamp_pos: assert property (p_clamp_pos) else $error("positive clamp wrong");

  property p_mid_code;
    @(negedge i_clock) disable iff (!i_arst_n)
      adv && (smp_i_q == '0) |=>
        s1_i_q == (($past(fmt_q) == DCADC_TWOS_COMP) ? 10'h000 : 10'h200);
  endproperty
  a_mid_code: assert property (p_mid_code) else $error("zero input code wrong for format");

  property p_sleep_wins;
    @(posedge i_clock) disable iff (!i_arst_n) sync2_q[0] && sync2_q[1] |=> o_sleeping && !o_quick_idle && !run_q;
  endproperty
  a_sleep_wins: assert property (p_sleep_wins) else $error("sleep did not take priority");

  property p_run_rate;
    @(posedge i_clock) disable iff (!i_arst_n) run_q && buf_ready && vld_q[2] |-> adv_seen_q;
  endproperty
  a_run_rate: assert property (p_run_rate) else $error("conversion skipped a cycle while running");

  c_parallel: cover property (@(posedge i_clock) disable iff (!i_arst_n) mode_q == DCADC_PARALLEL && adv_seen_q);
  c_muxed: cover property (@(posedge i_clock) disable iff (!i_arst_n) mode_q == DCADC_MUXED && adv_seen_q);
  c_stall: cover property (@(posedge i_clock) disable iff (!i_arst_n) run_q && !buf_ready);
  c_idle: cover property (@(posedge i_clock) disable iff (!i_arst_n) o_quick_idle [*3]);
endmodule

// >>> dcadc_capture.sv
`timescale 1ns/1ps
module dcadc_capture (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_word_valid,
  input wire logic [19:0] i_word,
  input wire logic [1:0] i_pace,
  output logic o_word_ready,
  output logic [19:0] o_last,
  output logic [15:0] o_count
);
  // Pace 0 takes every word, 1 takes one cycle in three, 2 stalls outright
  logic [1:0] tick_q;

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tick_q <= 2'h0;
      o_word_ready <= 1'b0;
    end else begin
      tick_q <= (tick_q == 2'h2) ? 2'h0 : tick_q + 2'h1;
      o_word_ready <= (i_pace == 2'h0) || (i_pace == 2'h1 && tick_q == 2'h0);
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_last <= 20'h00000;
      o_count <= 16'h0000;
    end else if (i_word_valid && o_word_ready) begin
      o_last <= i_word;
      o_count <= o_count + 16'h0001;
    end
  end
endmodule

// >>> dcadc_core_test.sv
`timescale 1ns/1ps
module dcadc_core_test;
  import dcadc_pkg::*;
  localparam int D = 5;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic signed [11:0] idf = 12'sh000;
  logic signed [11:0] qdf = 12'sh000;
  logic gain = 1'b0;
  logic bsel = 1'b1;
  logic fmt = 1'b1;
  logic slp = 1'b0;
  logic qid = 1'b0;
  logic [1:0] pace = 2'h0;
  logic [9:0] ibus;
  logic [9:0] qbus;
  logic phase, sleeping, qidle_o, wvalid, wready;
  logic [19:0] word, last;
  logic [15:0] cnt, c0, pc;
  int miscompares = 0;
  int checks_done = 0;
  int vals[9] = '{-600, 600, 0, 511, -512, -1, 2047, -2047, 1000};
  int prevj, found;

  always #25 clk = ~clk;

  dcadc_core dut (.i_clock(clk), .i_arst_n(arst_n), .i_i_diff(idf), .i_q_diff(qdf), .i_gain_select(gain),
    .i_bus_arrangement_select(bsel), .i_code_format_select(fmt), .i_sleep_request(slp),
    .i_quick_idle_request(qid), .o_i_bus(ibus), .o_q_bus(qbus), .o_chan_phase_q(phase),
    .o_sleeping(sleeping), .o_quick_idle(qidle_o), .o_word_valid(wvalid), .i_word_ready(wready), .o_word(word));
  dcadc_capture cap (.i_clock(clk), .i_arst_n(arst_n), .i_word_valid(wvalid), .i_word(word), .i_pace(pace),
    .o_word_ready(wready), .o_last(last), .o_count(cnt));

  function automatic logic [9:0] code(input int v, input logic g, input logic f);
    int s;
    s = g ? (v >>> 1) : v;
    if (s < -512) s = -512;
    if (s > 511) s = 511;
    return s[9:0] ^ (f ? 10'h000 : 10'h200);
  endfunction

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic drive(input int i, input int q);
    @(posedge clk);
    #D;
    idf = i[11:0];
    qdf = q[11:0];
  endtask

  // Long enough for the control synchronisers and the whole pipeline
  task automatic settle;
    repeat (8) @(posedge clk);
    #D;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #D;
  endtask

  task automatic lat(input logic m);
    bsel = m;
    drive(100, -200);
    settle();
    drive(300, -400);
    step(2);
    if (m) chk({ibus, qbus}, {code(100, 0, 1), code(-200, 0, 1)});
    else chk({ibus, 9'h000, phase}, {code(100, 0, 1), 10'h000});
    step(1);
    if (m) chk({ibus, qbus}, {code(300, 0, 1), code(-400, 0, 1)});
    else chk({ibus, qbus}, {code(300, 0, 1), 10'h000});
    @(negedge clk);
    #D;
    if (!m) chk({ibus, 9'h000, phase}, {code(-400, 0, 1), 10'h001});
    step(1);
  endtask

  initial begin
    step(4);
    chk({ibus, 9'h000, wvalid}, 20'h00000);
    @(posedge clk);
    #D;
    arst_n = 1'b1;
    for (int f = 0; f < 2; f++) begin
      for (int g = 0; g < 2; g++) begin
        for (int k = 0; k < 9; k++) begin
          drive(vals[k], -vals[k]);
          fmt = f[0];
          gain = g[0];
          settle();
          chk({ibus, qbus}, {code(vals[k], g[0], f[0]), code(-vals[k], g[0], f[0])});
          chk(last, {code(vals[k], g[0], f[0]), code(-vals[k], g[0], f[0])});
        end
      end
    end
    fmt = 1'b1;
    gain = 1'b0;
    lat(1'b1);
    lat(1'b0);
    bsel = 1'b1;
    drive(50, 60);
    settle();
    qid = 1'b1;
    settle();
    drive(-70, -80);
    settle();
    chk({ibus, qbus}, {code(50, 0, 1), code(60, 0, 1)});
    chk({18'h00000, sleeping, qidle_o}, 20'h00001);
    slp = 1'b1;
    settle();
    chk({18'h00000, sleeping, qidle_o}, 20'h00002);
    chk({ibus, qbus}, {code(50, 0, 1), code(60, 0, 1)});
    slp = 1'b0;
    qid = 1'b0;
    settle();
    chk({ibus, qbus}, {code(-70, 0, 1), code(-80, 0, 1)});
    // Ramp under stalls: each captured word must be a later ramp sample, never repeated
    fmt = 1'b0;
    prevj = -1;
    pc = cnt;
    c0 = cnt;
    for (int n = 0; n < 90; n++) begin
      drive(n * 3 - 100, n * 3 - 100);
      pace = (n < 5 || n >= 60) ? 2'h0 : (n < 15 ? 2'h2 : 2'h1);
      if (n == 8) c0 = cnt;
      if (n == 14) chk({3'h0, wvalid, cnt}, {4'h1, c0});
      if (n >= 6 && cnt !== pc) begin
        found = -1;
        for (int j = prevj + 1; j <= n; j++) begin
          if (last === {code(j * 3 - 100, 0, 0), code(j * 3 - 100, 0, 0)}) found = j;
        end
        chk({19'h00000, found > prevj}, 20'h00001);
        prevj = found;
      end
      pc = cnt;
    end
    chk({19'h00000, (cnt - c0) > 16'h000A}, 20'h00001);
    // Conversion must stop, or the stream never runs dry
    qid = 1'b1;
    found = 0;
    while (wvalid !== 1'b0 && found < 50) begin
      step(1);
      found++;
    end
    if (found >= 50) miscompares++;
    wrap_up();
  end
endmodule
